// File: ebw_pkg.sv
// constants and types shared by both ends of the block write protect link
// assumes a 10 MHz aclk on both ends

package ebw_pkg;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 100;
  localparam int SCL_PERIOD_NS = 800;
  // quarter of a link bit, least time so rounded up
  localparam int QTR_CYC =
    (SCL_PERIOD_NS / 4 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WC_TIME_US    = 5000;
  localparam int WC_CYC        = WC_TIME_US * 1000 / CLK_PERIOD_NS;

  // ---------------------------------------------------------------
  // control byte layout and codes
  // ---------------------------------------------------------------
  localparam int         CB_CODE_LSB = 4;
  localparam int         CB_CS_LSB   = 1;
  localparam int         CB_RW_BIT   = 0;
  localparam logic [3:0] CODE_PROT   = 4'h6;
  localparam logic [3:0] CODE_ARRAY  = 4'ha;
  localparam logic [2:0] CS_BLK0     = 3'h1;
  localparam logic [2:0] CS_BLK1     = 3'h4;
  localparam logic [2:0] CS_BLK2     = 3'h5;
  localparam logic [2:0] CS_BLK3     = 3'h0;
  localparam logic [2:0] CS_CLR      = 3'h3;
  localparam logic [1:0] DUMMY_BYTES = 2'h2;
  localparam int         NUM_BLK     = 4;
  localparam int         BLK_LSB     = 7;
  localparam logic [3:0] PROT_RST    = 4'h0;

  // command kinds held by the device while a frame runs
  localparam logic [2:0] K_NONE = 3'h0;
  localparam logic [2:0] K_SET  = 3'h1;
  localparam logic [2:0] K_CLR  = 3'h2;
  localparam logic [2:0] K_QRY  = 3'h3;
  localparam logic [2:0] K_WR   = 3'h4;

  // ---------------------------------------------------------------
  // host register map
  // ---------------------------------------------------------------
  localparam int         AXI_AW        = 4;
  localparam logic [3:0] REG_CMD       = 4'h0;
  localparam logic [3:0] REG_STAT      = 4'h4;
  localparam logic [3:0] REG_TXD       = 4'h8;
  localparam int         CMD_HV_BIT    = 8;
  localparam int         CMD_N_LSB     = 9;
  localparam int         STAT_BUSY_BIT = 0;
  localparam int         STAT_ACK_LSB  = 8;
  localparam logic [1:0] RESP_OKAY     = 2'h0;
  localparam logic [1:0] RESP_SLVERR   = 2'h2;

  // ---------------------------------------------------------------
  // state types
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    S_IDLE = 4'h1,
    S_RX   = 4'h2,
    S_ACK  = 4'h4,
    S_PASS = 4'h8
  } ebw_dst_type;

  typedef enum logic [3:0] {
    H_IDLE  = 4'h1,
    H_START = 4'h2,
    H_BIT   = 4'h4,
    H_STOP  = 4'h8
  } ebw_hst_type;

endpackage

// File: ebw_link_if.sv
// two-wire link between the protect controller and the eeprom end
// assumes open-drain wires with pull-ups; each end gives enables only, except hv, which the host drives directly
`timescale 1ns/100ps

interface ebw_link_if;
  logic scl_oe;
  logic h_sda_oe;
  logic d_sda_oe;
  logic hv;
  logic scl;
  logic sda;

  // pulled high unless some end pulls low
  assign scl = ~scl_oe;
  assign sda = ~(h_sda_oe | d_sda_oe);

  modport host (output scl_oe, output h_sda_oe, output hv, input sda);
  modport dev  (input scl, input sda, input hv, output d_sda_oe);
endinterface

// File: ebw_sync.sv
// two-flop synchroniser for levels entering the aclk domain
// assumes slow inputs; no pulse narrower than a clock is kept
`timescale 1ns/100ps

module ebw_sync
  import ebw_pkg::*;
#(
  parameter int             W       = 1,
  parameter logic [W-1:0]   RST_VAL = '0
)(
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic         ce,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_ff;
  logic [W-1:0] q_ff;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      meta_ff <= RST_VAL;
      q_ff    <= RST_VAL;
    end
    else if (ce)
    begin
      meta_ff <= d;
      q_ff    <= meta_ff;
    end
  end

  assign q = q_ff;
endmodule // ebw_sync

// File: ebw_dev.sv
// eeprom end: block write protect flags, their commands and write gating
// assumes aclk far faster than scl; the array engine sits outside
//
// Register access over AXI4-Lite and the placing of the registers are this design's own decisions.
`timescale 1ns/100ps

module ebw_dev
  import ebw_pkg::*;
#(
  parameter int unsigned WC_CYCLES = WC_CYC
)(
  input  wire logic  aclk,
  input  wire logic  aresetn,
  input  wire logic  ce,
  ebw_link_if.dev    link,
  input  wire logic  arr_bank,
  input  wire logic  nv_load,
  input  wire logic  [NUM_BLK-1:0] nv_image,
  output logic       [NUM_BLK-1:0] prot_flags,
  output logic       wc_busy,
  output logic       arr_data_valid,
  output logic [8:0] arr_addr,
  output logic [7:0] arr_data,
  output logic       arr_commit
);
  localparam int WCW = $clog2(WC_CYCLES + 1);

  // ---------------------------------------------------------------
  // pin sampling and bus conditions
  // ---------------------------------------------------------------
  logic [2:0] syn;
  logic       scl_s;
  logic       sda_s;
  logic       hv_s;
  logic       scl_d_ff;
  logic       sda_d_ff;

  ebw_sync #(.W(3), .RST_VAL(3'h6)) u_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .ce      (ce),
    .d       ({link.scl, link.sda, link.hv}),
    .q       (syn)
  );
  assign scl_s = syn[2];
  assign sda_s = syn[1];
  assign hv_s  = syn[0];

  wire scl_rise = scl_s & ~scl_d_ff;
  wire scl_fall = ~scl_s & scl_d_ff;
  wire start_c  = scl_s & scl_d_ff & sda_d_ff & ~sda_s;
  wire stop_c   = scl_s & scl_d_ff & ~sda_d_ff & sda_s;

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  ebw_dst_type      st_ff,   nxt_st;
  logic [2:0]       bit_ff,  nxt_bit;
  logic [7:0]       sh_ff,   nxt_sh;
  logic [1:0]       byte_ff, nxt_byte;
  logic [2:0]       kind_ff, nxt_kind;
  logic [1:0]       blk_ff,  nxt_blk;
  logic             pend_ff, nxt_pend;
  logic             ack_ff,  nxt_ack;
  logic             oe_ff,   nxt_oe;
  logic             wrote_ff, nxt_wrote;
  logic [7:0]       addr_ff, nxt_addr;
  logic [NUM_BLK-1:0] prot_ff, nxt_prot;
  logic [WCW-1:0]   wc_ff,   nxt_wc;
  logic             dv_ff,   nxt_dv;
  logic             cm_ff,   nxt_cm;
  logic [8:0]       aout_ff, nxt_aout;
  logic [7:0]       dout_ff, nxt_dout;

  // ---------------------------------------------------------------
  // control byte decode
  // ---------------------------------------------------------------
  wire [7:0] nb     = {sh_ff[6:0], sda_s};
  wire [3:0] code   = nb[CB_CODE_LSB +: 4];
  wire [2:0] cs     = nb[CB_CS_LSB +: 3];
  wire       rw     = nb[CB_RW_BIT];
  wire       is_prt = code == CODE_PROT;
  wire       is_arr = code == CODE_ARRAY;
  wire       cs_blk = (cs == CS_BLK0) | (cs == CS_BLK1) |
                      (cs == CS_BLK2) | (cs == CS_BLK3);
  wire [1:0] cs_idx = (cs == CS_BLK1) ? 2'h1 :
                      (cs == CS_BLK2) ? 2'h2 :
                      (cs == CS_BLK3) ? 2'h3 : 2'h0;
  wire       cs_prt = prot_ff[cs_idx];
  wire [2:0] k0 =
    (is_prt & rw & cs_blk)                  ? K_QRY :
    (is_prt & ~rw & (cs == CS_CLR) & hv_s)  ? K_CLR :
    (is_prt & ~rw & cs_blk & hv_s & ~cs_prt) ? K_SET :
    (is_arr & ~rw)                          ? K_WR  : K_NONE;

  // the write cycle blocks a start, so clear-all needs no busy test here
  wire       first  = byte_ff == 2'h0;
  wire       prt_k  = (kind_ff == K_SET) | (kind_ff == K_CLR);
  wire [1:0] wr_blk = {arr_bank, addr_ff[BLK_LSB]};
  wire       dat_pr = prot_ff[wr_blk];
  wire [2:0] dec_kind =
    first                                     ? k0 :
    (prt_k & (byte_ff > DUMMY_BYTES))         ? K_NONE :
    ((kind_ff == K_WR) & ~byte_ff[1])         ? kind_ff :
    ((kind_ff == K_WR) & dat_pr)              ? K_NONE :
    kind_ff;
  wire dec_ack = (first & (k0 == K_QRY)) ? ~cs_prt :
                 (dec_kind != K_NONE);
  wire abort   = prt_k & ~hv_s;
  wire apply   = prt_k & (byte_ff == 2'h3) & hv_s;
  wire busy    = wc_ff != '0;
  wire [NUM_BLK-1:0] set_mask = NUM_BLK'(1) << blk_ff;

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb
  begin
    nxt_st    = st_ff;
    nxt_bit   = bit_ff;
    nxt_sh    = sh_ff;
    nxt_byte  = byte_ff;
    nxt_kind  = kind_ff;
    nxt_blk   = blk_ff;
    nxt_pend  = pend_ff;
    nxt_ack   = ack_ff;
    nxt_oe    = oe_ff;
    nxt_wrote = wrote_ff;
    nxt_addr  = addr_ff;
    nxt_prot  = prot_ff;
    nxt_wc    = busy ? wc_ff - WCW'(1) : wc_ff;
    nxt_dv    = 1'b0;
    nxt_cm    = 1'b0;
    nxt_aout  = aout_ff;
    nxt_dout  = dout_ff;
    if (stop_c)
    begin
      nxt_st   = S_IDLE;
      nxt_kind = K_NONE;
      nxt_oe   = 1'b0;
      nxt_pend = 1'b0;
      if (apply)
      begin
        nxt_prot = (kind_ff == K_CLR) ? '0 : prot_ff | set_mask;
        nxt_wc   = WCW'(WC_CYCLES);
      end
      else if ((kind_ff == K_WR) & wrote_ff)
      begin
        nxt_cm = 1'b1;
        nxt_wc = WCW'(WC_CYCLES);
      end
      nxt_wrote = 1'b0;
    end
    else if (start_c)
    begin
      // refusing every start while busy keeps the bus free of acks
      nxt_st    = busy ? S_PASS : S_RX;
      nxt_kind  = K_NONE;
      nxt_oe    = 1'b0;
      nxt_bit   = 3'h0;
      nxt_byte  = 2'h0;
      nxt_pend  = 1'b0;
      nxt_wrote = 1'b0;
    end
    else if (abort)
    begin
      nxt_st   = S_PASS;
      nxt_kind = K_NONE;
      nxt_oe   = 1'b0;
      nxt_pend = 1'b0;
    end
    else
    begin
      case (st_ff)
        S_RX:
        begin
          if (scl_rise)
          begin
            nxt_sh  = nb;
            nxt_bit = bit_ff + 3'h1;
            if (bit_ff == 3'h7)
            begin
              nxt_kind = dec_kind;
              nxt_ack  = dec_ack;
              nxt_pend = 1'b1;
              if (first)
                nxt_blk = cs_idx;
            end
          end
          else if (scl_fall & pend_ff)
          begin
            nxt_st   = S_ACK;
            nxt_oe   = ack_ff;
            nxt_pend = 1'b0;
          end
        end
        S_ACK:
        begin
          if (scl_fall)
          begin
            nxt_oe   = 1'b0;
            nxt_byte = (byte_ff == 2'h3) ? byte_ff : byte_ff + 2'h1;
            if ((kind_ff == K_WR) & (byte_ff == 2'h1))
              nxt_addr = sh_ff;
            if ((kind_ff == K_WR) & byte_ff[1])
            begin
              nxt_dv    = 1'b1;
              nxt_wrote = 1'b1;
              nxt_aout  = {arr_bank, addr_ff};
              nxt_dout  = sh_ff;
              nxt_addr  = {addr_ff[7:4], addr_ff[3:0] + 4'h1};
            end
            // query and refused frames go quiet; released sda reads ones
            nxt_st = ((kind_ff == K_NONE) | (kind_ff == K_QRY)) ?
                     S_PASS : S_RX;
          end
        end
        S_IDLE:  nxt_st = S_IDLE;
        S_PASS:  nxt_st = S_PASS;
        default: nxt_st = S_IDLE;
      endcase
    end
    if (nv_load)
      nxt_prot = nv_image;
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st_ff    <= S_IDLE;
      bit_ff   <= 3'h0;
      sh_ff    <= 8'h00;
      byte_ff  <= 2'h0;
      kind_ff  <= K_NONE;
      blk_ff   <= 2'h0;
      pend_ff  <= 1'b0;
      ack_ff   <= 1'b0;
      oe_ff    <= 1'b0;
      wrote_ff <= 1'b0;
      scl_d_ff <= 1'b1;
      sda_d_ff <= 1'b1;
    end
    else if (ce)
    begin
      st_ff    <= nxt_st;
      bit_ff   <= nxt_bit;
      sh_ff    <= nxt_sh;
      byte_ff  <= nxt_byte;
      kind_ff  <= nxt_kind;
      blk_ff   <= nxt_blk;
      pend_ff  <= nxt_pend;
      ack_ff   <= nxt_ack;
      oe_ff    <= nxt_oe;
      wrote_ff <= nxt_wrote;
      scl_d_ff <= scl_s;
      sda_d_ff <= sda_s;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      addr_ff <= 8'h00;
      wc_ff   <= '0;
      dv_ff   <= 1'b0;
      cm_ff   <= 1'b0;
      aout_ff <= 9'h000;
      dout_ff <= 8'h00;
    end
    else if (ce)
    begin
      addr_ff <= nxt_addr;
      wc_ff   <= nxt_wc;
      dv_ff   <= nxt_dv;
      cm_ff   <= nxt_cm;
      aout_ff <= nxt_aout;
      dout_ff <= nxt_dout;
    end
  end

  // flags stand outside aresetn: they model nonvolatile bits
  always_ff @(posedge aclk)
  begin
    if (ce)
      prot_ff <= nxt_prot;
  end

  assign link.d_sda_oe  = oe_ff;
  assign prot_flags     = prot_ff;
  assign wc_busy        = busy;
  assign arr_data_valid = dv_ff;
  assign arr_addr       = aout_ff;
  assign arr_data       = dout_ff;
  assign arr_commit     = cm_ff;
endmodule // ebw_dev

// File: ebw_host.sv
// protect controller: AXI4-Lite registers drive one link frame per command
// assumes the eeprom end on the same link interface, scl made here
`timescale 1ns/100ps

module ebw_host
  import ebw_pkg::*;
(
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic              ce,
  ebw_link_if.host               link,
  input  wire logic [AXI_AW-1:0] awaddr,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  input  wire logic [AXI_AW-1:0] araddr,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready
);
  localparam int QDW = $clog2(QTR_CYC + 1);

  // ---------------------------------------------------------------
  // register slave
  // ---------------------------------------------------------------
  logic              aw_full_ff, w_full_ff, bvalid_ff, rvalid_ff;
  logic [AXI_AW-1:0] awaddr_ff;
  logic [31:0]       wdata_ff, rdata_ff;
  logic [3:0]        wstrb_ff;
  logic [1:0]        bresp_ff, rresp_ff;
  logic [15:0]       txd_ff;
  logic              sda_s;
  ebw_hst_type       st_ff, nxt_st;
  logic [11:0]       cmd_ff, nxt_cmd;
  logic [7:0]        acks_ff, nxt_acks;

  wire idle    = st_ff == H_IDLE;
  wire aw_hs   = awvalid & ~aw_full_ff;
  wire w_hs    = wvalid & ~w_full_ff;
  wire do_wr   = aw_full_ff & w_full_ff & ~bvalid_ff;
  wire wr_map  = (awaddr_ff == REG_CMD) | (awaddr_ff == REG_TXD);
  // a command write while a frame runs is dropped, answered OKAY
  wire wr_cmd  = do_wr & (awaddr_ff == REG_CMD) & (&wstrb_ff[1:0]) & idle;
  wire wr_txd  = do_wr & (awaddr_ff == REG_TXD);
  wire ar_hs   = arvalid & ~rvalid_ff;
  wire rd_map  = (araddr == REG_CMD) | (araddr == REG_STAT) |
                 (araddr == REG_TXD);
  wire [31:0] stat_w = {16'h0000, acks_ff, 7'h00, ~idle};
  wire [31:0] rd_mux = (araddr == REG_CMD)  ? {20'h00000, cmd_ff} :
                       (araddr == REG_STAT) ? stat_w :
                       (araddr == REG_TXD)  ? {16'h0000, txd_ff} : 32'h0;

  assign awready = ~aw_full_ff;
  assign wready  = ~w_full_ff;
  assign bvalid  = bvalid_ff;
  assign bresp   = bresp_ff;
  assign arready = ~rvalid_ff;
  assign rvalid  = rvalid_ff;
  assign rdata   = rdata_ff;
  assign rresp   = rresp_ff;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_full_ff <= 1'b0;
      w_full_ff  <= 1'b0;
      bvalid_ff  <= 1'b0;
      bresp_ff   <= RESP_OKAY;
      awaddr_ff  <= '0;
      wdata_ff   <= 32'h0;
      wstrb_ff   <= 4'h0;
    end
    else if (ce)
    begin
      aw_full_ff <= do_wr ? 1'b0 : (aw_full_ff | aw_hs);
      w_full_ff  <= do_wr ? 1'b0 : (w_full_ff | w_hs);
      if (aw_hs)
        awaddr_ff <= awaddr;
      if (w_hs)
      begin
        wdata_ff <= wdata;
        wstrb_ff <= wstrb;
      end
      if (do_wr)
      begin
        bvalid_ff <= 1'b1;
        bresp_ff  <= wr_map ? RESP_OKAY : RESP_SLVERR;
      end
      else if (bready)
        bvalid_ff <= 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_ff <= 1'b0;
      rdata_ff  <= 32'h0;
      rresp_ff  <= RESP_OKAY;
      txd_ff    <= 16'h0000;
    end
    else if (ce)
    begin
      if (ar_hs)
      begin
        rvalid_ff <= 1'b1;
        rdata_ff  <= rd_mux;
        rresp_ff  <= rd_map ? RESP_OKAY : RESP_SLVERR;
      end
      else if (rready)
        rvalid_ff <= 1'b0;
      if (wr_txd & wstrb_ff[0])
        txd_ff[7:0] <= wdata_ff[7:0];
      if (wr_txd & wstrb_ff[1])
        txd_ff[15:8] <= wdata_ff[15:8];
    end
  end

  // ---------------------------------------------------------------
  // frame engine, four quarters per scl period
  // ---------------------------------------------------------------
  logic [QDW-1:0] qd_ff;
  logic [1:0]     q_ff,    nxt_q;
  logic [3:0]     bit_ff,  nxt_bit;
  logic [2:0]     byte_ff, nxt_byte;
  logic           scl_oe_ff, nxt_scl_oe;
  logic           sda_oe_ff, nxt_sda_oe;
  logic           hv_ff,   nxt_hv;

  ebw_sync #(.W(1), .RST_VAL(1'b1)) u_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .ce      (ce),
    .d       (link.sda),
    .q       (sda_s)
  );

  wire       qtick   = ~idle & (qd_ff == QDW'(QTR_CYC - 1));
  wire [1:0] nq      = q_ff + 2'h1;
  wire [7:0] cur     = (byte_ff == 3'h0) ? cmd_ff[7:0] :
                       (byte_ff == 3'h1) ? txd_ff[7:0] : txd_ff[15:8];
  wire       tx      = (byte_ff == 3'h0) | ~cmd_ff[CB_RW_BIT];
  wire       cur_bit = cur[3'(4'h7 - bit_ff)];
  wire       last    = byte_ff == cmd_ff[CMD_N_LSB +: 3];

  always_comb
  begin
    nxt_st     = st_ff;
    nxt_cmd    = cmd_ff;
    nxt_acks   = acks_ff;
    nxt_q      = qtick ? nq : q_ff;
    nxt_bit    = bit_ff;
    nxt_byte   = byte_ff;
    nxt_scl_oe = scl_oe_ff;
    nxt_sda_oe = sda_oe_ff;
    nxt_hv     = hv_ff;
    case (st_ff)
      H_IDLE:
      begin
        if (wr_cmd)
        begin
          nxt_st   = H_START;
          nxt_cmd  = wdata_ff[11:0];
          nxt_hv   = wdata_ff[CMD_HV_BIT];
          nxt_acks = 8'h00;
          nxt_q    = 2'h0;
          nxt_bit  = 4'h0;
          nxt_byte = 3'h0;
        end
      end
      H_START:
      begin
        if (qtick & (nq == 2'h2))
          nxt_sda_oe = 1'b1;
        if (qtick & (nq == 2'h0))
        begin
          nxt_scl_oe = 1'b1;
          nxt_st     = H_BIT;
        end
      end
      H_BIT:
      begin
        if (qtick & (nq == 2'h1))
          nxt_sda_oe = tx & ~bit_ff[3] & ~cur_bit;
        if (qtick & (nq == 2'h2))
          nxt_scl_oe = 1'b0;
        if (qtick & (nq == 2'h0))
        begin
          nxt_scl_oe = 1'b1;
          if (bit_ff[3])
          begin
            if (tx)
              nxt_acks[byte_ff] = ~sda_s;
            nxt_bit = 4'h0;
            // all bytes go out even if refused; software reads acks
            if (last)
              nxt_st = H_STOP;
            else
              nxt_byte = byte_ff + 3'h1;
          end
          else
            nxt_bit = bit_ff + 4'h1;
        end
      end
      H_STOP:
      begin
        if (qtick & (nq == 2'h1))
          nxt_sda_oe = 1'b1;
        if (qtick & (nq == 2'h2))
          nxt_scl_oe = 1'b0;
        if (qtick & (nq == 2'h3))
          nxt_sda_oe = 1'b0;
        if (qtick & (nq == 2'h0))
        begin
          nxt_st = H_IDLE;
          nxt_hv = 1'b0;
        end
      end
      default: nxt_st = H_IDLE;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st_ff     <= H_IDLE;
      cmd_ff    <= 12'h000;
      acks_ff   <= 8'h00;
      qd_ff     <= '0;
      q_ff      <= 2'h0;
      bit_ff    <= 4'h0;
      byte_ff   <= 3'h0;
      scl_oe_ff <= 1'b0;
      sda_oe_ff <= 1'b0;
      hv_ff     <= 1'b0;
    end
    else if (ce)
    begin
      st_ff     <= nxt_st;
      cmd_ff    <= nxt_cmd;
      acks_ff   <= nxt_acks;
      qd_ff     <= (qtick | idle) ? '0 : qd_ff + QDW'(1);
      q_ff      <= nxt_q;
      bit_ff    <= nxt_bit;
      byte_ff   <= nxt_byte;
      scl_oe_ff <= nxt_scl_oe;
      sda_oe_ff <= nxt_sda_oe;
      hv_ff     <= nxt_hv;
    end
  end

  assign link.scl_oe   = scl_oe_ff;
  assign link.h_sda_oe = sda_oe_ff;
  assign link.hv       = hv_ff;
endmodule // ebw_host

// File: ebw_checker.sv
// checker: link and device flag relations, one aclk domain
// assumes the bench wires it beside the link interface by name
`timescale 1ns/100ps

module ebw_checker
  import ebw_pkg::*;
(
  input wire logic               aclk,
  input wire logic               aresetn,
  input wire logic               scl,
  input wire logic               sda,
  input wire logic               hv,
  input wire logic               d_sda_oe,
  input wire logic               nv_load,
  input wire logic               wc_busy,
  input wire logic [NUM_BLK-1:0] prot_flags
);
  // ----------
  // properties
  // ----------
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // nv_load edges excluded: a power-up image may set many flags
  property p_one_set;
    !$past(nv_load) |-> $countones(prot_flags & ~$past(prot_flags)) < 2;
  endproperty
  a_one_set: assert property (p_one_set) else $error("two flags set at once");
  property p_clr_all;
    !$past(nv_load) && (~prot_flags & $past(prot_flags)) != 4'h0
      |-> prot_flags == 4'h0;
  endproperty
  a_clr_all: assert property (p_clr_all) else $error("partial unprotect");
  // hv falls on the edge the stop is seen, one edge before flags show
  property p_flag_hv;
    !$past(nv_load) && $changed(prot_flags) |-> $past(hv, 2);
  endproperty
  a_flag_hv: assert property (p_flag_hv) else $error("flags moved without hv");
  property p_flag_wc;
    !$past(nv_load) && $changed(prot_flags) |-> ##[0:2] wc_busy;
  endproperty
  a_flag_wc: assert property (p_flag_wc) else $error("no write cycle");
  property p_quiet;
    wc_busy |-> !d_sda_oe;
  endproperty
  a_quiet: assert property (p_quiet) else $error("ack during write cycle");
  property p_wc_len;
    $rose(wc_busy) |=> wc_busy [*8] ##[1:500] !wc_busy;
  endproperty
  a_wc_len: assert property (p_wc_len) else $error("write cycle length");
  property p_hv_hold;
    $fell(hv) |-> scl && sda;
  endproperty
  a_hv_hold: assert property (p_hv_hold) else $error("hv dropped in frame");
  // sda moves only while scl is low, else it reads as start or stop
  property p_ack_edge;
    scl && $past(scl) |-> $stable(d_sda_oe);
  endproperty
  a_ack_edge: assert property (p_ack_edge) else $error("sda moved, scl high");
  c_wc: cover property ($rose(wc_busy));
  c_ack_hv: cover property (d_sda_oe && hv);
  c_clr: cover property ($fell(|prot_flags));
endmodule // ebw_checker

// File: eeprom_block_write_protect_bench.sv
// bench: host and eeprom ends face each other, driven over AXI4-Lite
// assumes WC_CYCLES 400 so a write cycle outlasts one short frame
`timescale 1ns/100ps

module eeprom_block_write_protect_bench
  import ebw_pkg::*;
;
  logic aclk, aresetn, nv_load, arr_bank, awvalid, wvalid, bready, arvalid;
  logic rready, awready, wready, bvalid, arready, rvalid, wc_busy;
  logic [3:0] awaddr, araddr, wstrb, nv_image, prot_flags;
  logic [31:0] wdata, rdata, d;
  logic [1:0] bresp, rresp, r;
  logic dv, cm;
  logic [8:0] aa;
  logic [7:0] ad;
  logic [2:0] cs [4] = '{CS_BLK0, CS_BLK1, CS_BLK2, CS_BLK3};
  int bad_count = 0, checks = 0, cyc = 0, ncm = 0;
  ebw_link_if lnk ();
  ebw_host u_ebw_host (.aclk, .aresetn, .ce(1'b1), .link(lnk), .awaddr,
    .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid,
    .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready);
  ebw_dev #(.WC_CYCLES(400)) u_ebw_dev (.aclk, .aresetn, .ce(1'b1),
    .link(lnk), .arr_bank, .nv_load, .nv_image, .prot_flags, .wc_busy,
    .arr_data_valid(dv), .arr_addr(aa), .arr_data(ad), .arr_commit(cm));
  ebw_checker u_ebw_checker (.aclk, .aresetn, .scl(lnk.scl), .sda(lnk.sda),
    .hv(lnk.hv), .d_sda_oe(lnk.d_sda_oe), .nv_load, .wc_busy, .prot_flags);
  // ----------
  // tasks
  // ----------
  task test_done;
    if (bad_count == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task chk(input logic [7:0] g, input logic [7:0] e);
    checks++;
    if (g !== e) begin
      bad_count++;
      $display("unexpected at %0t: got %h exp %h", $time, g, e);
    end
  endtask
  task wr(input logic [3:0] a, input logic [31:0] v);
    logic pa, pw;
    pa = 1'b1;
    pw = 1'b1;
    @(posedge aclk);
    {awaddr, wdata, wstrb, awvalid, wvalid} <= {a, v, 4'hf, 2'b11};
    bready <= 1'b1;
    // each channel drops on its own handshake edge
    while (pa || pw)
    begin
      @(negedge aclk);
      {pa, pw} = {pa & ~awready, pw & ~wready};
      @(posedge aclk);
      {awvalid, wvalid} <= {pa, pw};
    end
    @(negedge aclk);
    while (!bvalid) @(negedge aclk);
    r = bresp;
    @(posedge aclk);
    bready <= 1'b0;
  endtask
  task rd(input logic [3:0] a, output logic [31:0] v, output logic [1:0] s);
    @(posedge aclk);
    {araddr, arvalid} <= {a, 1'b1};
    @(negedge aclk);
    while (!arready) @(negedge aclk);
    @(posedge aclk);
    {arvalid, rready} <= 2'b01;
    @(negedge aclk);
    while (!rvalid) @(negedge aclk);
    {v, s} = {rdata, rresp};
    @(posedge aclk);
    rready <= 1'b0;
  endtask
  // one frame, then the acked bytes of it against e
  task cmd(input logic [7:0] c, input logic h, input logic [2:0] n,
           input logic [7:0] e);
    wr(REG_CMD, {20'h0, n, h, c});
    d = 32'h1;
    while (d[0]) rd(REG_STAT, d, r);
    chk(d[15:8] & ((8'h2 << n) - 8'h1), e);
  endtask
  task wwc;
    @(negedge aclk);
    while (wc_busy) @(negedge aclk);
    @(posedge aclk);
  endtask
  // ----------
  // sequence
  // ----------
  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end
  initial begin
    forever
    begin
      @(posedge aclk);
      cyc++;
      if (cyc == 40000) begin bad_count++; test_done; end
    end
  end
  // array strobes counted between edges, where they are settled
  always @(negedge aclk) ncm += dv + cm;
  initial begin
    {aresetn, nv_load, nv_image, arr_bank} = 7'b0100000;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
    {awaddr, araddr, wstrb, wdata} = 44'h0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (3) @(posedge aclk);
    nv_load <= 1'b0;
    for (int i = 0; i < 4; i++)
    begin
      cmd({CODE_PROT, cs[i], 1'b1}, 1'b0, 3'h3, 8'h01);
      cmd({CODE_PROT, cs[i], 1'b0}, 1'b1, 3'h2, 8'h07);
      cmd({CODE_PROT, cs[i], 1'b1}, 1'b1, 3'h1, 8'h00);
      wwc;
      cmd({CODE_PROT, cs[i], 1'b0}, 1'b1, 3'h2, 8'h00);
      chk({7'h0, wc_busy}, 8'h00);
      cmd({CODE_PROT, cs[i], 1'b1}, 1'b0, 3'h1, 8'h00);
      chk({4'h0, prot_flags}, 8'((2 << i) - 1));
    end
    arr_bank <= 1'b1;
    wr(REG_TXD, 32'h5a80);
    chk({6'h0, r}, {6'h0, RESP_OKAY});
    cmd({CODE_ARRAY, 3'h0, 1'b0}, 1'b0, 3'h2, 8'h03);
    cmd({CODE_PROT, CS_CLR, 1'b0}, 1'b1, 3'h2, 8'h07);
    wwc;
    chk({4'h0, prot_flags}, 8'h00);
    cmd({CODE_PROT, CS_BLK2, 1'b0}, 1'b0, 3'h2, 8'h00);
    cmd({CODE_PROT, CS_BLK2, 1'b0}, 1'b1, 3'h2, 8'h07);
    wwc;
    wr(REG_TXD, 32'h3c00);
    cmd({CODE_ARRAY, 3'h0, 1'b0}, 1'b0, 3'h2, 8'h03);
    arr_bank <= 1'b0;
    wr(REG_TXD, 32'h3c7f);
    cmd({CODE_ARRAY, 3'h0, 1'b0}, 1'b0, 3'h2, 8'h07);
    wwc;
    chk(ad, 8'h3c);
    chk(aa[7:0], 8'h7f);
    chk(aa[8:1], 8'h3f);
    chk(8'(ncm), 8'h02);
    aresetn <= 1'b0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    chk({4'h0, prot_flags}, 8'h04);
    rd(4'hc, d, r);
    chk({6'h0, r}, {6'h0, RESP_SLVERR});
    wr(4'hc, 32'h0);
    chk({6'h0, r}, {6'h0, RESP_SLVERR});
    test_done;
  end
endmodule // eeprom_block_write_protect_bench
